//--- hw/plti_defines.svh
// constants for the lane transceiver interface: offsets, fields, timing
`ifndef PLTI_DEFINES_SVH
`define PLTI_DEFINES_SVH

`define PLTI_LANES 4
`define PLTI_ADDR_W 12
`define PLTI_BSTAT_W 6
`define PLTI_IRQ_W 6
`define PLTI_CNT_W 16

`define PLTI_OFS_CTRL 12'h000
`define PLTI_OFS_STATUS 12'h004
`define PLTI_OFS_IRQ_STAT 12'h008
`define PLTI_OFS_IRQ_MASK 12'h00C
`define PLTI_OFS_ERRCNT 12'h010

`define PLTI_CTRL_INH_LSB 0
`define PLTI_CTRL_BOND 4
`define PLTI_CTRL_SWRST 5
`define PLTI_CTRL_INH_RST 4'h0
`define PLTI_CTRL_BOND_RST 1'b1

`define PLTI_ST_DONE_LSB 0
`define PLTI_ST_ALIGN_LSB 4
`define PLTI_ST_READY 8
`define PLTI_ST_FLOW 9
`define PLTI_ST_BSTAT_LSB 10
`define PLTI_ST_REQ 16

`define PLTI_IRQ_REQ 0
`define PLTI_IRQ_DONE 1
`define PLTI_IRQ_DEC 2
`define PLTI_IRQ_DISP 3
`define PLTI_IRQ_LOST 4
`define PLTI_IRQ_BOND 5
`define PLTI_IRQ_MASK_RST 6'h00

`define PLTI_BSTAT_SAT 6'h1E
`define PLTI_LOW5_ONES 5'h1F

`define PLTI_CLK_PERIOD_NS 10
`define PLTI_RST_HOLD_NS 100
`define PLTI_RST_HOLD_CYC \
    ((`PLTI_RST_HOLD_NS + `PLTI_CLK_PERIOD_NS - 1) / `PLTI_CLK_PERIOD_NS)

`endif

//--- hw/plti_pkg.sv
// types and helper functions for the lane transceiver interface
package plti_pkg;
    `include "plti_defines.svh"

    typedef logic [`PLTI_LANES-1:0] plti_lane_t;
    typedef logic [4*`PLTI_LANES-1:0] plti_kflag_t;
    typedef logic [32*`PLTI_LANES-1:0] plti_sym_t;
    typedef logic [`PLTI_BSTAT_W-1:0] plti_bstat_t;

    typedef enum logic [1:0] {
        RST_HOLD = 2'b00,
        RST_WAIT = 2'b01,
        RST_RUN = 2'b10
    } plti_rst_state_t;

    typedef struct packed {
        plti_lane_t inh;
        logic bond_en;
        logic swrst;
        logic [`PLTI_IRQ_W-1:0] irq_stat;
        logic [`PLTI_IRQ_W-1:0] irq_mask;
        logic [31:0] prdata;
        logic ack;
        logic slverr;
        plti_sym_t tx_data;
        plti_kflag_t tx_k;
        plti_bstat_t buf_stat;
        logic flow;
        logic req_prev;
        logic [`PLTI_CNT_W-1:0] errcnt;
    } plti_top_st_t;

    typedef struct packed {
        plti_rst_state_t st;
        logic [7:0] cnt;
        logic gt_reset;
        logic ready;
        logic done_evt;
    } plti_rst_st_t;

    typedef struct packed {
        plti_sym_t data;
        plti_kflag_t k;
        plti_kflag_t comma;
        logic valid;
        plti_lane_t aligned;
        logic dec;
        logic disp;
        logic lost;
        logic bond;
    } plti_rx_st_t;

    function automatic logic plti_all_set(input plti_lane_t v);
        return &v;
    endfunction

    function automatic logic plti_mapped(input logic [`PLTI_ADDR_W-1:0] a);
        return (a == `PLTI_OFS_CTRL) || (a == `PLTI_OFS_STATUS) ||
               (a == `PLTI_OFS_IRQ_STAT) || (a == `PLTI_OFS_IRQ_MASK) ||
               (a == `PLTI_OFS_ERRCNT);
    endfunction
endpackage

//--- hw/plti_rst_if.sv
// reset handshake bundle between the top and the reset sequencer
`timescale 1ns/1ps
interface plti_rst_if;
    logic reset_req;
    logic [`PLTI_LANES-1:0] reset_done;
    logic sw_reset;
    logic gt_reset;
    logic rx_ready;
    logic done_evt;

    modport seq (
        input reset_req,
        input reset_done,
        input sw_reset,
        output gt_reset,
        output rx_ready,
        output done_evt
    );

    modport ctl (
        output reset_req,
        output reset_done,
        output sw_reset,
        input gt_reset,
        input rx_ready,
        input done_evt
    );
endinterface

//--- hw/plti_rst_seq.sv
// transceiver reset sequencer: hold, wait for all lanes done, run
`timescale 1ns/1ps
module plti_rst_seq (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // reset handshake
    plti_rst_if.seq rb
);
    import plti_pkg::*;

    localparam logic [7:0] HOLD_LAST = 8'(`PLTI_RST_HOLD_CYC - 1);

    plti_rst_st_t state_ff, nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.done_evt = 1'b0;
        // a request restarts the hold in any state, data is cut one cycle after gt_reset rises
        if (rb.reset_req || rb.sw_reset) begin
            nxt_state.st = RST_HOLD;
            nxt_state.cnt = HOLD_LAST;
            nxt_state.gt_reset = 1'b1;
            nxt_state.ready = 1'b0;
        end else begin
            unique case (state_ff.st)
                RST_HOLD: begin
                    if (state_ff.cnt == 8'h00) begin
                        nxt_state.st = RST_WAIT;
                        nxt_state.gt_reset = 1'b0;
                    end else begin
                        nxt_state.cnt = state_ff.cnt - 8'h01;
                    end
                end
                RST_WAIT: begin
                    if (plti_all_set(rb.reset_done)) begin
                        nxt_state.st = RST_RUN;
                        nxt_state.ready = 1'b1;
                        nxt_state.done_evt = 1'b1;
                    end
                end
                RST_RUN: begin
                    if (!plti_all_set(rb.reset_done)) begin
                        nxt_state.st = RST_WAIT;
                        nxt_state.ready = 1'b0;
                    end
                end
                default: begin
                    nxt_state.st = RST_HOLD;
                    nxt_state.cnt = HOLD_LAST;
                    nxt_state.gt_reset = 1'b1;
                    nxt_state.ready = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '0;
            state_ff.st <= RST_HOLD;
            state_ff.cnt <= HOLD_LAST;
            state_ff.gt_reset <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rb.gt_reset = state_ff.gt_reset;
    assign rb.rx_ready = state_ff.ready;
    assign rb.done_evt = state_ff.done_evt;
endmodule // plti_rst_seq

//--- hw/plti_rx_lanes.sv
// receive lane capture: gated symbols and error events from any byte
`timescale 1ns/1ps
module plti_rx_lanes (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic rx_ready,
    input wire logic bond_en,
    // from transceivers
    input wire plti_pkg::plti_sym_t gtrx_data,
    input wire plti_pkg::plti_kflag_t gtrx_charisk,
    input wire plti_pkg::plti_kflag_t gtrx_chariscomma,
    input wire plti_pkg::plti_kflag_t gtrx_disperr,
    input wire plti_pkg::plti_kflag_t gtrx_notintable,
    input wire plti_pkg::plti_lane_t gtrx_chanbondseq,
    input wire plti_pkg::plti_lane_t gtrx_chanisaligned,
    // toward the phy
    output plti_pkg::plti_sym_t rx_sym,
    output plti_pkg::plti_kflag_t rx_k,
    output plti_pkg::plti_kflag_t rx_comma,
    output logic rx_valid,
    output plti_pkg::plti_lane_t aligned,
    // one-cycle events
    output logic dec_evt,
    output logic disp_evt,
    output logic lost_evt,
    output logic bond_evt
);
    import plti_pkg::*;

    plti_rx_st_t state_ff, nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.aligned = gtrx_chanisaligned;
        nxt_state.bond = |gtrx_chanbondseq;
        // lanes in reset send garbage, so no symbol or error event passes before ready
        nxt_state.valid = rx_ready;
        nxt_state.data = rx_ready ? gtrx_data : '0;
        nxt_state.k = rx_ready ? gtrx_charisk : '0;
        nxt_state.comma = rx_ready ? gtrx_chariscomma : '0;
        nxt_state.disp = rx_ready && (|gtrx_disperr);
        nxt_state.dec = rx_ready && (|gtrx_notintable);
        nxt_state.lost = rx_ready && bond_en &&
                         (|(state_ff.aligned & ~gtrx_chanisaligned));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rx_sym = state_ff.data;
    assign rx_k = state_ff.k;
    assign rx_comma = state_ff.comma;
    assign rx_valid = state_ff.valid;
    assign aligned = state_ff.aligned;
    assign dec_evt = state_ff.dec;
    assign disp_evt = state_ff.disp;
    assign lost_evt = state_ff.lost;
    assign bond_evt = state_ff.bond;
endmodule // plti_rx_lanes

//--- hw/plti_top.sv
// lane transceiver interface top: apb registers, tx path, rx and reset
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
//
// Behaviour
// - thirty-two transmit bits per lane.
// - one transmit K flag per byte.
// - one transmitter disable per lane.
// - one channel bonding enable output.
// - one transceiver reset output.
module plti_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PLTI_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // transmit symbols from the phy
    input wire plti_pkg::plti_sym_t tx_sym_in,
    input wire plti_pkg::plti_kflag_t tx_k_in,
    // receive symbols toward the phy
    output plti_pkg::plti_sym_t rx_sym_out,
    output plti_pkg::plti_kflag_t rx_k_out,
    output plti_pkg::plti_kflag_t rx_comma_out,
    output logic rx_valid_out,
    // packet buffer
    input wire plti_pkg::plti_bstat_t buf_stat_in,
    input wire logic tx_flow_control_in,
    output plti_pkg::plti_bstat_t buf_stat_out,
    output logic tx_flow_mode_out,
    // transceiver transmit side
    output plti_pkg::plti_sym_t gttx_data,
    output plti_pkg::plti_kflag_t gttx_charisk,
    output plti_pkg::plti_lane_t gttx_inhibit,
    // transceiver receive side
    input wire plti_pkg::plti_sym_t gtrx_data,
    input wire plti_pkg::plti_kflag_t gtrx_charisk,
    input wire plti_pkg::plti_kflag_t gtrx_chariscomma,
    input wire plti_pkg::plti_kflag_t gtrx_disperr,
    input wire plti_pkg::plti_kflag_t gtrx_notintable,
    input wire plti_pkg::plti_lane_t gtrx_chanbondseq,
    input wire plti_pkg::plti_lane_t gtrx_chanisaligned,
    // transceiver bonding and reset
    output logic gtrx_chanbonden,
    input wire logic gtrx_reset_req,
    output logic gtrx_reset,
    input wire plti_pkg::plti_lane_t gtrx_reset_done
);
    import plti_pkg::*;

    plti_top_st_t state_ff, nxt_state;
    plti_lane_t rx_aligned;
    logic dec_evt;
    logic disp_evt;
    logic lost_evt;
    logic bond_evt;
    logic access;
    logic wr_take;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic [`PLTI_IRQ_W-1:0] events;
    logic [`PLTI_IRQ_W-1:0] w1c;
    logic err_hit;
    logic err_clr;

    plti_rst_if rst_bus ();

    function automatic logic [31:0] lane_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    function automatic logic [31:0] read_word(
        input logic [`PLTI_ADDR_W-1:0] a,
        input plti_top_st_t s,
        input plti_lane_t done,
        input plti_lane_t algn,
        input logic ready,
        input logic req
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (a)
            `PLTI_OFS_CTRL: begin
                w[`PLTI_CTRL_INH_LSB +: `PLTI_LANES] = s.inh;
                w[`PLTI_CTRL_BOND] = s.bond_en;
            end
            `PLTI_OFS_STATUS: begin
                w[`PLTI_ST_DONE_LSB +: `PLTI_LANES] = done;
                w[`PLTI_ST_ALIGN_LSB +: `PLTI_LANES] = algn;
                w[`PLTI_ST_READY] = ready;
                w[`PLTI_ST_FLOW] = s.flow;
                w[`PLTI_ST_BSTAT_LSB +: `PLTI_BSTAT_W] = s.buf_stat;
                w[`PLTI_ST_REQ] = req;
            end
            `PLTI_OFS_IRQ_STAT: w[`PLTI_IRQ_W-1:0] = s.irq_stat;
            `PLTI_OFS_IRQ_MASK: w[`PLTI_IRQ_W-1:0] = s.irq_mask;
            `PLTI_OFS_ERRCNT: w[`PLTI_CNT_W-1:0] = s.errcnt;
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    assign rst_bus.reset_req = gtrx_reset_req;
    assign rst_bus.reset_done = gtrx_reset_done;
    assign rst_bus.sw_reset = state_ff.swrst;

    plti_rst_seq u_rst_seq (
        .pclk(pclk),
        .presetn(presetn),
        .rb(rst_bus.seq)
    );

    plti_rx_lanes u_rx_lanes (
        .pclk(pclk),
        .presetn(presetn),
        .rx_ready(rst_bus.rx_ready),
        .bond_en(state_ff.bond_en),
        .gtrx_data(gtrx_data),
        .gtrx_charisk(gtrx_charisk),
        .gtrx_chariscomma(gtrx_chariscomma),
        .gtrx_disperr(gtrx_disperr),
        .gtrx_notintable(gtrx_notintable),
        .gtrx_chanbondseq(gtrx_chanbondseq),
        .gtrx_chanisaligned(gtrx_chanisaligned),
        .rx_sym(rx_sym_out),
        .rx_k(rx_k_out),
        .rx_comma(rx_comma_out),
        .rx_valid(rx_valid_out),
        .aligned(rx_aligned),
        .dec_evt(dec_evt),
        .disp_evt(disp_evt),
        .lost_evt(lost_evt),
        .bond_evt(bond_evt)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_state.swrst = 1'b0;
        nxt_state.ack = 1'b0;
        access = psel && penable;
        // one wait state so read data always comes from a flip-flop
        wr_take = access && state_ff.ack && pwrite && !state_ff.slverr;
        wmask = lane_mask(pstrb);
        wval = pwdata & wmask;
        w1c = '0;
        err_clr = 1'b0;

        if (access && !state_ff.ack) begin
            nxt_state.ack = 1'b1;
            nxt_state.slverr = !plti_mapped(paddr);
            nxt_state.prdata = pwrite ? 32'h0000_0000 :
                read_word(paddr, state_ff, gtrx_reset_done, rx_aligned,
                          rst_bus.rx_ready, gtrx_reset_req);
        end

        if (wr_take) begin
            unique case (paddr)
                `PLTI_OFS_CTRL: begin
                    if (pstrb[0]) begin
                        nxt_state.inh =
                            pwdata[`PLTI_CTRL_INH_LSB +: `PLTI_LANES];
                        nxt_state.bond_en = pwdata[`PLTI_CTRL_BOND];
                        nxt_state.swrst = pwdata[`PLTI_CTRL_SWRST];
                    end
                end
                `PLTI_OFS_IRQ_STAT: w1c = wval[`PLTI_IRQ_W-1:0];
                `PLTI_OFS_IRQ_MASK: begin
                    if (pstrb[0]) begin
                        nxt_state.irq_mask = pwdata[`PLTI_IRQ_W-1:0];
                    end
                end
                `PLTI_OFS_ERRCNT: err_clr = 1'b1;
                default: begin
                end
            endcase
        end

        events = '0;
        events[`PLTI_IRQ_REQ] = gtrx_reset_req && !state_ff.req_prev;
        events[`PLTI_IRQ_DONE] = rst_bus.done_evt;
        events[`PLTI_IRQ_DEC] = dec_evt;
        events[`PLTI_IRQ_DISP] = disp_evt;
        events[`PLTI_IRQ_LOST] = lost_evt;
        events[`PLTI_IRQ_BOND] = bond_evt;
        nxt_state.req_prev = gtrx_reset_req;
        // a new event wins over a clear written in the same cycle
        nxt_state.irq_stat = (state_ff.irq_stat & ~w1c) | events;

        err_hit = dec_evt || disp_evt;
        if (err_clr) begin
            nxt_state.errcnt = err_hit ? `PLTI_CNT_W'(1) : '0;
        end else if (err_hit && !(&state_ff.errcnt)) begin
            nxt_state.errcnt = state_ff.errcnt + `PLTI_CNT_W'(1);
        end

        nxt_state.tx_data = tx_sym_in;
        nxt_state.tx_k = tx_k_in;
        // guards the link against a pattern the partner reads as flow control
        if (buf_stat_in[4:0] == `PLTI_LOW5_ONES ||
            buf_stat_in > `PLTI_BSTAT_SAT) begin
            nxt_state.buf_stat = `PLTI_BSTAT_SAT;
        end else begin
            nxt_state.buf_stat = buf_stat_in;
        end
        nxt_state.flow = tx_flow_control_in;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '0;
            state_ff.inh <= `PLTI_CTRL_INH_RST;
            state_ff.bond_en <= `PLTI_CTRL_BOND_RST;
            state_ff.irq_mask <= `PLTI_IRQ_MASK_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign pready = access && state_ff.ack;
    assign pslverr = access && state_ff.ack && state_ff.slverr;
    assign prdata = state_ff.prdata;
    assign irq = |(state_ff.irq_stat & state_ff.irq_mask);
    assign gttx_data = state_ff.tx_data;
    assign gttx_charisk = state_ff.tx_k;
    assign gttx_inhibit = state_ff.inh;
    assign gtrx_chanbonden = state_ff.bond_en;
    assign gtrx_reset = rst_bus.gt_reset;
    assign buf_stat_out = state_ff.buf_stat;
    assign tx_flow_mode_out = state_ff.flow;
endmodule // plti_top

//--- tb/plti_top_monitor.sv
// concurrent checks on the lane transceiver interface top ports
`timescale 1ns/1ps
module plti_top_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // transmit
    input wire plti_pkg::plti_sym_t tx_sym_in,
    input wire plti_pkg::plti_kflag_t tx_k_in,
    input wire plti_pkg::plti_sym_t gttx_data,
    input wire plti_pkg::plti_kflag_t gttx_charisk,
    // packet buffer
    input wire plti_pkg::plti_bstat_t buf_stat_in,
    input wire plti_pkg::plti_bstat_t buf_stat_out,
    input wire logic tx_flow_control_in,
    input wire logic tx_flow_mode_out,
    // receive
    input wire plti_pkg::plti_sym_t gtrx_data,
    input wire plti_pkg::plti_kflag_t gtrx_charisk,
    input wire plti_pkg::plti_sym_t rx_sym_out,
    input wire plti_pkg::plti_kflag_t rx_k_out,
    input wire logic rx_valid_out,
    // reset handshake
    input wire logic gtrx_reset_req,
    input wire logic gtrx_reset,
    input wire plti_pkg::plti_lane_t gtrx_reset_done
);
    import plti_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    tx_path_a: assert property (
        $past(presetn) |-> gttx_data == $past(tx_sym_in)
        && gttx_charisk == $past(tx_k_in))
        else $error("tx symbols lost");
    buf_clamp_a: assert property (
        $past(presetn) |-> buf_stat_out == ($past(buf_stat_in) > 6'h1E
        ? 6'h1E : $past(buf_stat_in)))
        else $error("bad clamp");
    flow_mode_a: assert property (
        $past(presetn) |-> tx_flow_mode_out == $past(tx_flow_control_in))
        else $error("bad flow mode");
    apb_wait_a: assert property (
        psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("apb wait state wrong");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("lone slverr");
    rx_pass_a: assert property (
        rx_valid_out |-> rx_sym_out == $past(gtrx_data)
        && rx_k_out == $past(gtrx_charisk))
        else $error("rx symbols lost");
    rx_gate_a: assert property (
        !rx_valid_out |-> rx_sym_out == '0 && rx_k_out == '0)
        else $error("rx data leak");
    req_reset_a: assert property (gtrx_reset_req |=> gtrx_reset)
        else $error("request ignored");
    hold_len_a: assert property (
        $fell(gtrx_reset_req) |-> gtrx_reset[*8] ##[2:4] !gtrx_reset)
        else $error("bad reset hold");
    hold_quiet_a: assert property (
        gtrx_reset && $past(gtrx_reset) |-> !rx_valid_out)
        else $error("valid in reset");
    done_gate_a: assert property (
        $rose(rx_valid_out) |-> &$past(gtrx_reset_done, 2))
        else $error("early ready");
    cover property ($rose(rx_valid_out));
    cover property ($fell(gtrx_reset_req));
    cover property (pslverr);
endmodule // plti_top_monitor

//--- tb/plti_gt_model.sv
// behavioural serial transceiver set: loopback, reset done, bonding
`timescale 1ns/1ps
module plti_gt_model (
    // clock
    input wire logic pclk,
    // from the block
    input wire logic gt_reset,
    input wire logic bond_en,
    input wire plti_pkg::plti_lane_t inhibit,
    input wire plti_pkg::plti_sym_t tx_data,
    input wire plti_pkg::plti_kflag_t tx_k,
    // bench commands
    input wire logic req_cmd,
    input wire plti_pkg::plti_kflag_t err_cmd,
    input wire plti_pkg::plti_lane_t bseq_cmd,
    input wire logic [7:0] done_dly,
    // toward the block
    output plti_pkg::plti_sym_t rx_data,
    output plti_pkg::plti_kflag_t rx_k,
    output plti_pkg::plti_kflag_t rx_comma,
    output plti_pkg::plti_kflag_t rx_disperr,
    output plti_pkg::plti_kflag_t rx_notintable,
    output plti_pkg::plti_lane_t rx_bondseq,
    output plti_pkg::plti_lane_t rx_aligned,
    output logic reset_req,
    output plti_pkg::plti_lane_t reset_done
);
    import plti_pkg::*;
    int cnt;
    // faults only on bench command, never on its own
    assign reset_req = req_cmd;
    initial begin
        cnt = 0;
        rx_data = '0;
        reset_done = '0;
    end
    always @(posedge pclk) begin
        cnt <= gt_reset ? 0 : cnt + 1;
        for (int i = 0; i < `PLTI_LANES; i++) begin
            // lanes finish one cycle apart, done_dly sets when lane 0 finishes
            reset_done[i] <= !gt_reset && cnt >= done_dly + i;
            // a dead or inhibited lane flips its bits every cycle
            rx_data[32*i +: 32] <= (reset_done[i] && !inhibit[i]) ?
                tx_data[32*i +: 32] : ~rx_data[32*i +: 32];
        end
        for (int b = 0; b < 4*`PLTI_LANES; b++) begin
            rx_comma[b] <= tx_k[b] && tx_data[8*b +: 8] == 8'hBC;
        end
        rx_k <= tx_k;
        rx_disperr <= err_cmd;
        rx_notintable <= err_cmd;
        rx_bondseq <= bseq_cmd & reset_done;
        rx_aligned <= bond_en ? reset_done : '0;
    end
endmodule // plti_gt_model

//--- tb/tb.sv
// self-checking bench for the lane transceiver interface top
`timescale 1ns/1ps
module tb;
    import plti_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, e;
    logic [`PLTI_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic pready, pslverr, irq, rx_valid_out, tx_flow_control_in;
    logic tx_flow_mode_out, gtrx_chanbonden, gtrx_reset_req, gtrx_reset;
    plti_sym_t tx_sym_in, rx_sym_out, gttx_data, gtrx_data;
    plti_kflag_t tx_k_in, rx_k_out, rx_comma_out, gttx_charisk, err_cmd;
    plti_kflag_t gtrx_charisk, gtrx_chariscomma, gtrx_disperr;
    plti_kflag_t gtrx_notintable;
    plti_lane_t gttx_inhibit, gtrx_chanbondseq, gtrx_chanisaligned;
    plti_lane_t gtrx_reset_done, bseq_cmd;
    plti_bstat_t buf_stat_in, buf_stat_out;
    logic req_cmd;
    logic [7:0] done_dly;
    int num_errors, checked;
    plti_top DUT (.*);
    plti_gt_model u_gt (
        .pclk(pclk), .gt_reset(gtrx_reset), .bond_en(gtrx_chanbonden),
        .inhibit(gttx_inhibit), .tx_data(gttx_data), .tx_k(gttx_charisk),
        .req_cmd(req_cmd), .err_cmd(err_cmd), .bseq_cmd(bseq_cmd),
        .done_dly(done_dly), .rx_data(gtrx_data), .rx_k(gtrx_charisk),
        .rx_comma(gtrx_chariscomma), .rx_disperr(gtrx_disperr),
        .rx_notintable(gtrx_notintable), .rx_bondseq(gtrx_chanbondseq),
        .rx_aligned(gtrx_chanisaligned), .reset_req(gtrx_reset_req),
        .reset_done(gtrx_reset_done)
    );
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk_w(input plti_sym_t got, input plti_sym_t exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        e = pslverr;
        if (n >= 50) num_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk_w(rd & m, x);
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        while (rx_valid_out !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
        end
        chk_w(rx_valid_out, 32'h1);
    endtask
    task automatic t_regs();
        rdc(`PLTI_OFS_CTRL, '1, 32'h10);
        chk_w({gtrx_chanbonden, gttx_inhibit}, 32'h10);
        apb(1'b1, `PLTI_OFS_CTRL, 32'h5);
        repeat (2) @(posedge pclk);
        chk_w({gtrx_chanbonden, gttx_inhibit}, 32'h5);
        rdc(12'h020, '1, 32'h0);
        chk_w(e, 32'h1);
        apb(1'b1, `PLTI_OFS_CTRL, 32'h10);
        $display("t_regs done");
    endtask
    task automatic t_tx();
        plti_sym_t s;
        // byte 6 holds the comma code but is not flagged as a K byte
        s = 128'hA5A5_0000_1234_5678_9ABC_DEF0_C3C3_00BC;
        tx_sym_in <= s;
        tx_k_in <= 16'h8001;
        repeat (6) @(posedge pclk);
        chk_w(gttx_data, s);
        chk_w(gttx_charisk, 32'h8001);
        chk_w(rx_sym_out, s);
        chk_w({rx_k_out, rx_comma_out}, 32'h8001_0001);
        $display("t_tx done");
    endtask
    task automatic t_buf();
        logic [5:0] v [6] = '{6'h00, 6'h1D, 6'h1E, 6'h1F, 6'h20, 6'h3F};
        logic [5:0] x;
        foreach (v[i]) begin
            buf_stat_in <= v[i];
            tx_flow_control_in <= v[i][0];
            x = v[i] > 6'h1E ? 6'h1E : v[i];
            repeat (3) @(posedge pclk);
            chk_w(buf_stat_out, x);
            chk_w(tx_flow_mode_out, v[i][0]);
        end
        $display("t_buf done");
    endtask
    task automatic err_pulse();
        err_cmd <= 16'h0100;
        @(posedge pclk);
        err_cmd <= '0;
        repeat (5) @(posedge pclk);
    endtask
    task automatic t_err();
        apb(1'b1, `PLTI_OFS_IRQ_STAT, 32'h3F);
        apb(1'b1, `PLTI_OFS_ERRCNT, 32'h0);
        apb(1'b1, `PLTI_OFS_IRQ_MASK, 32'hC);
        err_pulse();
        chk_w(irq, 32'h1);
        rdc(`PLTI_OFS_IRQ_STAT, 32'hC, 32'hC);
        rdc(`PLTI_OFS_ERRCNT, '1, 32'h1);
        apb(1'b1, `PLTI_OFS_IRQ_STAT, 32'hC);
        repeat (2) @(posedge pclk);
        chk_w(irq, 32'h0);
        apb(1'b1, `PLTI_OFS_IRQ_MASK, 32'h0);
        err_pulse();
        chk_w(irq, 32'h0);
        rdc(`PLTI_OFS_IRQ_STAT, 32'hC, 32'hC);
        rdc(`PLTI_OFS_ERRCNT, '1, 32'h2);
        $display("t_err done");
    endtask
    task automatic t_bond();
        apb(1'b1, `PLTI_OFS_IRQ_STAT, 32'h3F);
        bseq_cmd <= 4'hA;
        @(posedge pclk);
        bseq_cmd <= '0;
        repeat (4) @(posedge pclk);
        rdc(`PLTI_OFS_IRQ_STAT, 32'h20, 32'h20);
        rdc(`PLTI_OFS_STATUS, 32'hF0, 32'hF0);
        apb(1'b1, `PLTI_OFS_CTRL, 32'h0);
        repeat (4) @(posedge pclk);
        rdc(`PLTI_OFS_STATUS, 32'hF0, 32'h0);
        apb(1'b1, `PLTI_OFS_CTRL, 32'h10);
        $display("t_bond done");
    endtask
    task automatic t_reset();
        int n;
        int m;
        apb(1'b1, `PLTI_OFS_IRQ_STAT, 32'h3F);
        done_dly <= 8'd40;
        req_cmd <= 1'b1;
        @(posedge pclk);
        req_cmd <= 1'b0;
        n = 0;
        m = 0;
        while (gtrx_reset !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        while (gtrx_reset === 1'b1 && m < 100) begin
            @(posedge pclk);
            m++;
        end
        chk_w(32'(m), 32'(`PLTI_RST_HOLD_CYC));
        chk_w(rx_sym_out | rx_valid_out, '0);
        wait_rdy();
        rdc(`PLTI_OFS_STATUS, 32'h10F, 32'h10F);
        rdc(`PLTI_OFS_IRQ_STAT, 32'h3, 32'h3);
        done_dly <= 8'd2;
        apb(1'b1, `PLTI_OFS_CTRL, 32'h30);
        repeat (3) @(posedge pclk);
        chk_w(gtrx_reset, 32'h1);
        wait_rdy();
        $display("t_reset done");
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        num_errors = 0;
        checked = 0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
        tx_sym_in = '0;
        tx_k_in = '0;
        buf_stat_in = '0;
        tx_flow_control_in = 1'b0;
        req_cmd = 1'b0;
        err_cmd = '0;
        bseq_cmd = '0;
        done_dly = 8'd3;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        wait_rdy();
        t_regs();
        t_tx();
        t_buf();
        t_err();
        t_bond();
        t_reset();
        print_verdict();
    end
    // some eighty times the expected run length
    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end
endmodule // tb
bind plti_top plti_top_monitor u_mon (.*);
